//--- csrt_map.vh
// Register map, field positions, reset values and timing of the CSR block.
//
// Functional notes
// [R1] Bit 16 enables normal-class interrupts globally.
// [R2] Bit 15 enables abnormal-class interrupts globally.
// [R3] Tx-stopped interrupt needs bit 1 and bit 15.
// [R4] Tx-done interrupt needs bit 0 and bit 16.
// [R5] Lost counter counts drops, clears on read.
// [R6] Overflow flag at bit 16, sticky until cleared.
// [R7] Bit 18 selects PHY write (0) or read (1).
// [R8] Bit 19 shows PHY management read data.
// [R9] Bit 17 drives PHY management data out.
// [R10] Bit 16 drives PHY management clock pin.
// [R11] EEPROM read, write, select control bits 14,13,11.
// [R12] Bit 3 shows EEPROM serial data in.
// [R13] Bit 2 drives EEPROM serial data pin.
// [R14] Software toggles bit 1 for EEPROM clock.
// [R15] Bit 0 drives EEPROM chip select.
// [R16] Timer loads bits 15:0, decrements every 204 us.
// [R17] Timer bit 16 selects continuous mode.
// [R18] At zero: flag set; reload if continuous.
// [R19] Lost counter wraps to zero on overflow.

`ifndef CSRT_MAP_VH
`define CSRT_MAP_VH

// ----------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------
`define CSRT_OFF_IRQ_EN   8'h38
`define CSRT_OFF_LOST     8'h40
`define CSRT_OFF_SERIAL   8'h48
`define CSRT_OFF_TIMER    8'h58
`define CSRT_OFF_WAKE     8'h68
`define CSRT_OFF_STATUS   8'h70
`define CSRT_OFF_MASK     8'h74

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSRT_IE_NORMAL    16
`define CSRT_IE_ABNORMAL  15
`define CSRT_IE_TXSTOP    1
`define CSRT_IE_TXDONE    0
`define CSRT_LOST_OVF     16
`define CSRT_SP_MGMT_IN   19
`define CSRT_SP_DIR       18
`define CSRT_SP_MGMT_OUT  17
`define CSRT_SP_MGMT_CLK  16
`define CSRT_SP_RD_CTL    14
`define CSRT_SP_WR_CTL    13
`define CSRT_SP_SEL_CTL   11
`define CSRT_SP_ROM_OUT   3
`define CSRT_SP_ROM_IN    2
`define CSRT_SP_ROM_CLK   1
`define CSRT_SP_ROM_CS    0
`define CSRT_TMR_CONT     16
`define CSRT_ST_TXDONE    0
`define CSRT_ST_TXSTOP    1
`define CSRT_ST_LOSTOVF   2
`define CSRT_ST_TIMER     3

// ----------------------------------------------------------------
// Reset values, write masks and timing
// ----------------------------------------------------------------
`define CSRT_SP_RESET     32'h0004000E
`define CSRT_WAKE_WMASK   32'h7E030700
`define CSRT_TICK_NS      204000
`define CSRT_CLK_NS       40
`define CSRT_TICK_CYC     (`CSRT_TICK_NS / `CSRT_CLK_NS)

`endif

//--- csrt_top.v
// CSR bank: interrupt enables, lost counter, serial port, timer.
`timescale 1ns/1ns
`include "csrt_map.vh"

module csrt_top #(
   parameter integer TICK_CYCLES = `CSRT_TICK_CYC,
   parameter integer PRE_W       = 13
) (
   input  wire        core_clk,
   input  wire        resetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout,
   output reg         hresp,
   output reg  [31:0] hrdata,
   input  wire        tx_done_evt,
   input  wire        tx_stopped_evt,
   input  wire        pkt_lost_evt,
   input  wire        mgmt_data_pin,
   output reg         mgmt_clk,
   output reg         mgmt_write_bit,
   output reg         mgmt_write_oe,
   input  wire        rom_data_pin,
   output reg         eeprom_data_to_rom,
   output reg         eeprom_sclk,
   output reg         eeprom_chip_select,
   output reg         eeprom_read_ctl,
   output reg         eeprom_write_ctl,
   output reg         eeprom_select_ctl,
   output reg         irq
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Address match on the low byte; upper address bits alias.
   function hit;
      input [7:0] a;
      input [7:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   // Prescaler constants are cut to the counter width on purpose.
   localparam integer     TICK_LAST_I = TICK_CYCLES - 1;
   localparam [PRE_W-1:0] TICK_LAST   = TICK_LAST_I[PRE_W-1:0];
   localparam [PRE_W-1:0] PRE_ONE     = {{(PRE_W-1){1'b0}}, 1'b1};

   // ----------------------------------------------------------------
   // Bus front end
   // ----------------------------------------------------------------

   reg        wr_pend;
   reg  [7:0] wr_addr;
   // Transfer size is not decoded; every access moves a whole word.
   wire       acc    = hsel & htrans[1] & hready;
   wire       rd_acc = acc & ~hwrite;
   wire       wr_acc = acc & hwrite;
   wire [7:0] a_addr = haddr[7:0];

   // Writes land in the data phase, when hwdata is valid.
   wire wr_ie     = wr_pend & hit(wr_addr, `CSRT_OFF_IRQ_EN);
   wire wr_lost   = wr_pend & hit(wr_addr, `CSRT_OFF_LOST);
   wire wr_serial = wr_pend & hit(wr_addr, `CSRT_OFF_SERIAL);
   wire wr_timer  = wr_pend & hit(wr_addr, `CSRT_OFF_TIMER);
   wire wr_wake   = wr_pend & hit(wr_addr, `CSRT_OFF_WAKE);
   wire wr_mask   = wr_pend & hit(wr_addr, `CSRT_OFF_MASK);

   // Read side effects happen at the address-phase edge.
   wire rd_lost   = rd_acc & hit(a_addr, `CSRT_OFF_LOST);
   wire rd_status = rd_acc & hit(a_addr, `CSRT_OFF_STATUS);

   // Address phase capture; the slave never inserts wait states.
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wr_pend   <= 1'b0;
         wr_addr   <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend   <= wr_acc;
         wr_addr   <= wr_acc ? a_addr : wr_addr;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt enable register
   // ----------------------------------------------------------------

   reg normal_summary_enable;
   reg abnormal_summary_enable;
   reg tx_stopped_irq_enable;
   reg tx_done_irq_enable;

   // Only the four enables owned here are stored.
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         normal_summary_enable   <= 1'b0;
         abnormal_summary_enable <= 1'b0;
         tx_stopped_irq_enable   <= 1'b0;
         tx_done_irq_enable      <= 1'b0;
      end else if (wr_ie) begin
         normal_summary_enable   <= hwdata[`CSRT_IE_NORMAL];   // [R1]
         abnormal_summary_enable <= hwdata[`CSRT_IE_ABNORMAL]; // [R2]
         tx_stopped_irq_enable   <= hwdata[`CSRT_IE_TXSTOP];
         tx_done_irq_enable      <= hwdata[`CSRT_IE_TXDONE];
      end
   end

   // ----------------------------------------------------------------
   // Lost packet counter
   // ----------------------------------------------------------------

   reg  [15:0] lost_packet_tally;
   reg         lost_count_overflow;
   reg  [15:0] next_lost_tally;
   reg         next_lost_ovf;
   reg  [15:0] lost_base;
   reg         lost_wrap;
   wire        ovf_clr = rd_lost | (wr_lost & hwdata[`CSRT_LOST_OVF]);

   // A drop in the read cycle is kept: the count restarts at one.
   always @* begin
      lost_base = rd_lost ? 16'h0000 : lost_packet_tally; // [R5]
      lost_wrap = pkt_lost_evt & (lost_base == 16'hFFFF);
      if (pkt_lost_evt) begin
         next_lost_tally = lost_base + 16'h0001; // [R5] [R19]
      end else begin
         next_lost_tally = lost_base;
      end
      next_lost_ovf = (lost_count_overflow & ~ovf_clr) | lost_wrap; // [R6]
   end

   // Counter and flag update.
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         lost_packet_tally   <= 16'h0000;
         lost_count_overflow <= 1'b0;
      end else begin
         lost_packet_tally   <= next_lost_tally;
         lost_count_overflow <= next_lost_ovf;
      end
   end

   // ----------------------------------------------------------------
   // Pin input synchronisers
   // ----------------------------------------------------------------

   reg [2:0] mgmt_sync;
   reg [2:0] rom_sync;
   reg       mgmt_read_bit;
   reg       eeprom_data_from_rom;

   // Stage 0 feeds stage 1 only; a level is taken once 1 and 2 agree.
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mgmt_sync            <= 3'h0;
         rom_sync             <= 3'h7;
         mgmt_read_bit        <= 1'b0;
         eeprom_data_from_rom <= 1'b1;
      end else begin
         mgmt_sync <= {mgmt_sync[1:0], mgmt_data_pin};
         rom_sync  <= {rom_sync[1:0], rom_data_pin};
         if (mgmt_sync[1] == mgmt_sync[2]) begin
            mgmt_read_bit <= mgmt_sync[2]; // [R8]
         end
         if (rom_sync[1] == rom_sync[2]) begin
            eeprom_data_from_rom <= rom_sync[2]; // [R12]
         end
      end
   end

   // ----------------------------------------------------------------
   // Serial port register
   // ----------------------------------------------------------------

   reg mgmt_dir;

   // Pins follow the written bits directly; software does the timing.
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         // Direction resets to read, so the data pin driver starts off.
         mgmt_dir           <= 1'b1;
         mgmt_write_oe      <= 1'b0;
         mgmt_write_bit     <= 1'b0;
         mgmt_clk           <= 1'b0;
         eeprom_read_ctl    <= 1'b0;
         eeprom_write_ctl   <= 1'b0;
         eeprom_select_ctl  <= 1'b0;
         eeprom_data_to_rom <= 1'b1;
         eeprom_sclk        <= 1'b1;
         eeprom_chip_select <= 1'b0;
      end else if (wr_serial) begin
         mgmt_dir           <= hwdata[`CSRT_SP_DIR];       // [R7]
         mgmt_write_oe      <= ~hwdata[`CSRT_SP_DIR];      // [R7] [R9]
         mgmt_write_bit     <= hwdata[`CSRT_SP_MGMT_OUT];  // [R9]
         mgmt_clk           <= hwdata[`CSRT_SP_MGMT_CLK];  // [R10]
         eeprom_read_ctl    <= hwdata[`CSRT_SP_RD_CTL];    // [R11]
         eeprom_write_ctl   <= hwdata[`CSRT_SP_WR_CTL];    // [R11]
         eeprom_select_ctl  <= hwdata[`CSRT_SP_SEL_CTL];   // [R11]
         eeprom_data_to_rom <= hwdata[`CSRT_SP_ROM_IN];    // [R13]
         eeprom_sclk        <= hwdata[`CSRT_SP_ROM_CLK];   // [R14]
         eeprom_chip_select <= hwdata[`CSRT_SP_ROM_CS];    // [R15]
      end
   end

   // ----------------------------------------------------------------
   // General-purpose timer
   // ----------------------------------------------------------------

   reg [15:0]      timer_load_value;
   reg [15:0]      tmr_count;
   reg             tmr_cont;
   reg [PRE_W-1:0] pre_cnt;
   reg             timer_fire;
   wire            tick = (pre_cnt == TICK_LAST);

   // A write restarts the prescaler, so the first step is a full period.
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         timer_load_value <= 16'h0000;
         tmr_count        <= 16'h0000;
         tmr_cont         <= 1'b0;
         pre_cnt          <= {PRE_W{1'b0}};
         timer_fire       <= 1'b0;
      end else begin
         timer_fire <= 1'b0;
         if (wr_timer) begin
            timer_load_value <= hwdata[15:0];            // [R16]
            tmr_count        <= hwdata[15:0];            // [R16]
            tmr_cont         <= hwdata[`CSRT_TMR_CONT];  // [R17]
            pre_cnt          <= {PRE_W{1'b0}};
         end else if (tmr_count != 16'h0000) begin
            if (tick) begin
               pre_cnt <= {PRE_W{1'b0}};
               if (tmr_count == 16'h0001) begin
                  timer_fire <= 1'b1;                    // [R18]
                  tmr_count  <= tmr_cont ? timer_load_value
                                         : 16'h0000;     // [R17] [R18]
               end else begin
                  tmr_count <= tmr_count - 16'h0001;     // [R16]
               end
            end else begin
               pre_cnt <= pre_cnt + PRE_ONE;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Wake-up control header
   // ----------------------------------------------------------------

   reg [31:0] wake_ctl;

   // Enable bits are stored only; event bits belong elsewhere.
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wake_ctl <= 32'h00000000;
      end else if (wr_wake) begin
         wake_ctl <= hwdata & `CSRT_WAKE_WMASK;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status, mask and output
   // ----------------------------------------------------------------

   reg  [3:0] irq_status;
   reg  [3:0] irq_mask;
   wire [3:0] irq_evt;
   wire [3:0] irq_gate;

   assign irq_evt[`CSRT_ST_TXDONE]  = tx_done_evt;
   assign irq_evt[`CSRT_ST_TXSTOP]  = tx_stopped_evt;
   assign irq_evt[`CSRT_ST_LOSTOVF] = lost_wrap;
   assign irq_evt[`CSRT_ST_TIMER]   = timer_fire;

   // Transmit sources also need their summary enable.
   assign irq_gate[`CSRT_ST_TXDONE] =
      tx_done_irq_enable & normal_summary_enable;      // [R4] [R1]
   assign irq_gate[`CSRT_ST_TXSTOP] =
      tx_stopped_irq_enable & abnormal_summary_enable; // [R3] [R2]
   assign irq_gate[`CSRT_ST_LOSTOVF] = 1'b1;
   assign irq_gate[`CSRT_ST_TIMER]   = 1'b1;

   // Read clears status; an event in that cycle sets it again.
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq_status <= 4'h0;
         irq_mask   <= 4'h0;
         irq        <= 1'b0;
      end else begin
         irq_status <= (rd_status ? 4'h0 : irq_status) | irq_evt;
         if (wr_mask) begin
            irq_mask <= hwdata[3:0];
         end
         irq <= |(irq_status & irq_mask & irq_gate); // [R3] [R4]
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------

   reg [31:0] rd_mux;

   // Reserved and unmapped bits read as zero.
   always @* begin
      rd_mux = 32'h00000000;
      case (a_addr)
         `CSRT_OFF_IRQ_EN: begin
            rd_mux[`CSRT_IE_NORMAL]   = normal_summary_enable;
            rd_mux[`CSRT_IE_ABNORMAL] = abnormal_summary_enable;
            rd_mux[`CSRT_IE_TXSTOP]   = tx_stopped_irq_enable;
            rd_mux[`CSRT_IE_TXDONE]   = tx_done_irq_enable;
         end
         `CSRT_OFF_LOST: begin
            rd_mux[15:0]           = lost_packet_tally;
            rd_mux[`CSRT_LOST_OVF] = lost_count_overflow;
         end
         `CSRT_OFF_SERIAL: begin
            rd_mux[`CSRT_SP_MGMT_IN]  = mgmt_read_bit;
            rd_mux[`CSRT_SP_DIR]      = mgmt_dir;
            rd_mux[`CSRT_SP_MGMT_OUT] = mgmt_write_bit;
            rd_mux[`CSRT_SP_MGMT_CLK] = mgmt_clk;
            rd_mux[`CSRT_SP_RD_CTL]   = eeprom_read_ctl;
            rd_mux[`CSRT_SP_WR_CTL]   = eeprom_write_ctl;
            rd_mux[`CSRT_SP_SEL_CTL]  = eeprom_select_ctl;
            rd_mux[`CSRT_SP_ROM_OUT]  = eeprom_data_from_rom;
            rd_mux[`CSRT_SP_ROM_IN]   = eeprom_data_to_rom;
            rd_mux[`CSRT_SP_ROM_CLK]  = eeprom_sclk;
            rd_mux[`CSRT_SP_ROM_CS]   = eeprom_chip_select;
         end
         `CSRT_OFF_TIMER: begin
            rd_mux[15:0]           = tmr_count;
            rd_mux[`CSRT_TMR_CONT] = tmr_cont;
         end
         `CSRT_OFF_WAKE: begin
            rd_mux = wake_ctl;
         end
         `CSRT_OFF_STATUS: begin
            rd_mux[3:0] = irq_status;
         end
         `CSRT_OFF_MASK: begin
            rd_mux[3:0] = irq_mask;
         end
         default: begin
            rd_mux = 32'h00000000;
         end
      endcase
   end

   // Sampled at the address phase so the data phase needs no wait.
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         hrdata <= 32'h00000000;
      end else if (rd_acc) begin
         hrdata <= rd_mux;
      end
   end

endmodule

//--- csrt_monitor.sv
// Concurrent checks on the serial port pins of the CSR bank.
`timescale 1ns/1ns

module csrt_monitor (
   input wire        core_clk,
   input wire        resetn,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire        mgmt_clk,
   input wire        mgmt_write_bit,
   input wire        mgmt_write_oe,
   input wire        eeprom_data_to_rom,
   input wire        eeprom_sclk,
   input wire        eeprom_chip_select,
   input wire        eeprom_read_ctl,
   input wire        eeprom_write_ctl,
   input wire        eeprom_select_ctl
);
   // ------------------------------------------------------------
   // Serial port write decode
   // ------------------------------------------------------------
   // Address phase of a write to the serial port register.
   wire ser_adr = hsel && htrans[1] && hready && hwrite &&
                  (haddr[7:0] == 8'h48);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // Address phase, then the data phase whose edge moves the pins.
   sequence s_ser_wr;
      ser_adr ##1 1'b1;
   endsequence

   // ------------------------------------------------------------
   // Pin checks
   // ------------------------------------------------------------
   a_mgmt_clk_pin: assert property (
      s_ser_wr |=> mgmt_clk == $past(hwdata[16]))
      else $error("management clock does not follow its bit");
   a_mgmt_data_pin: assert property (
      s_ser_wr |=> mgmt_write_bit == $past(hwdata[17]))
      else $error("management data does not follow its bit");
   a_mgmt_dir_oe: assert property (
      s_ser_wr |=> mgmt_write_oe == !$past(hwdata[18]))
      else $error("management drive enable wrong for direction");
   a_rom_ctl_bits: assert property (
      s_ser_wr |=> {eeprom_read_ctl, eeprom_write_ctl, eeprom_select_ctl}
                   == {$past(hwdata[14]), $past(hwdata[13]),
                       $past(hwdata[11])})
      else $error("eeprom control bits do not follow writes");
   a_rom_data_pin: assert property (
      s_ser_wr |=> eeprom_data_to_rom == $past(hwdata[2]))
      else $error("eeprom data pin does not follow its bit");
   a_rom_clk_pin: assert property (
      s_ser_wr |=> eeprom_sclk == $past(hwdata[1]))
      else $error("eeprom clock pin does not follow its bit");
   a_rom_cs_pin: assert property (
      s_ser_wr |=> eeprom_chip_select == $past(hwdata[0]))
      else $error("eeprom chip select does not follow its bit");
   // Without a serial write two edges back none of the six clock, data, enable and select pins may move.
   a_pins_held: assert property (
      !$past(ser_adr, 2) |-> $stable({mgmt_clk, mgmt_write_bit,
         mgmt_write_oe, eeprom_data_to_rom, eeprom_sclk,
         eeprom_chip_select}))
      else $error("serial pin changed without a register write");
endmodule

//--- csrt_far_model.sv
// Behavioural management PHY and serial EEPROM on the far side.
`timescale 1ns/1ns

module csrt_far_model #(
   parameter logic [15:0] PHY_WORD = 16'hA5C3,
   parameter logic [15:0] ROM_WORD = 16'h6C39
) (
   input  wire  mgmt_clk,
   input  wire  mgmt_write_bit,
   input  wire  mgmt_write_oe,
   output wire  mgmt_data_pin,
   input  wire  eeprom_sclk,
   input  wire  eeprom_chip_select,
   output wire  rom_data_pin
);
   logic [3:0] phy_idx = 4'hF;
   logic [3:0] rom_idx = 4'hF;
   logic       phy_bit = 1'b1;
   logic       rom_bit = 1'b0;

   // The PHY shifts a bit out on each rising clock of a read.
   always @(posedge mgmt_clk or posedge mgmt_write_oe) begin
      if (mgmt_write_oe) begin
         phy_idx <= 4'hF;
      end else begin
         phy_bit <= PHY_WORD[phy_idx];
         phy_idx <= phy_idx - 4'h1;
      end
   end

   // Whoever enables its driver owns the management line.
   assign mgmt_data_pin = mgmt_write_oe ? mgmt_write_bit : phy_bit;

   // The EEPROM shifts only while selected, so software clocks it.
   always @(posedge eeprom_sclk or negedge eeprom_chip_select) begin
      if (!eeprom_chip_select) begin
         rom_idx <= 4'hF;
      end else begin
         rom_bit <= ROM_WORD[rom_idx];
         rom_idx <= rom_idx - 4'h1;
      end
   end

   // A deselected part floats; show the inverse so stale data fails.
   assign rom_data_pin = eeprom_chip_select ? rom_bit : ~rom_bit;
endmodule

//--- test_csr_counter_serial_timer.sv
// Self-checking bench for the CSR bank and its far-side model.
`timescale 1ns/1ns
`include "csrt_map.vh"
`define CHK(got, exp) begin samples_checked++; \
   if ((got) !== (exp)) begin bad_count++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end

module test_csr_counter_serial_timer;
   logic        core_clk = 1'b0;
   logic        resetn, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic        tx_done_evt, tx_stopped_evt, pkt_lost_evt;
   wire         hreadyout, hresp, mgmt_data_pin, rom_data_pin, irq;
   wire         mgmt_clk, mgmt_write_bit, mgmt_write_oe;
   wire         eeprom_data_to_rom, eeprom_sclk, eeprom_chip_select;
   wire         eeprom_read_ctl, eeprom_write_ctl, eeprom_select_ctl;
   int          bad_count = 0;
   int          samples_checked = 0;
   wire [8:0]   pins = {mgmt_clk, mgmt_write_bit, mgmt_write_oe,
      eeprom_read_ctl, eeprom_write_ctl, eeprom_select_ctl,
      eeprom_data_to_rom, eeprom_sclk, eeprom_chip_select};
   localparam logic [15:0] PHY_W = 16'hA5C3;
   localparam logic [15:0] ROM_W = 16'h6C39;

   // A short tick keeps the timer scenarios brief.
   csrt_top #(.TICK_CYCLES(4)) csrt_top_inst (.core_clk, .resetn,
      .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tx_done_evt,
      .tx_stopped_evt, .pkt_lost_evt, .mgmt_data_pin, .mgmt_clk,
      .mgmt_write_bit, .mgmt_write_oe, .rom_data_pin,
      .eeprom_data_to_rom, .eeprom_sclk, .eeprom_chip_select,
      .eeprom_read_ctl, .eeprom_write_ctl, .eeprom_select_ctl, .irq);
   csrt_far_model #(.PHY_WORD(PHY_W), .ROM_WORD(ROM_W))
      csrt_far_model_inst (.mgmt_clk, .mgmt_write_bit, .mgmt_write_oe,
      .mgmt_data_pin, .eeprom_sclk, .eeprom_chip_select, .rom_data_pin);

   // ------------------------------------------------------------
   // Bus and event tasks
   // ------------------------------------------------------------
   // One single transfer; each call starts after an idle edge.
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      `CHK({hresp, r & m}, {1'b0, e})
   endtask
   task automatic pulse(input logic [2:0] e, input int n);
      @(posedge core_clk);
      {pkt_lost_evt, tx_stopped_evt, tx_done_evt} <= e;
      repeat (n) @(posedge core_clk);
      {pkt_lost_evt, tx_stopped_evt, tx_done_evt} <= 3'h0;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_serial();
      logic [31:0] p [2] = '{32'h00050802, 32'h00F2F005};
      logic [8:0]  x;
      `CHK(pins, 9'h006)
      chk_rd(8'h48, 32'hFFF7FFF7, `CSRT_SP_RESET & 32'hFFF7FFF7);
      foreach (p[i]) begin
         x = {p[i][16], p[i][17], ~p[i][18], p[i][14], p[i][13],
              p[i][11], p[i][2], p[i][1], p[i][0]};
         wr(8'h48, p[i]);
         @(negedge core_clk);
         `CHK(pins, x)
         // Reserved bits written as one must read back as zero.
         chk_rd(8'h48, 32'hFFF7FFF7, p[i] & 32'h00076807);
      end
   endtask
   // Software clocks both serial parts and reads back the first four bits of each.
   task automatic t_bitbang();
      logic [31:0] x;
      wr(8'h48, 32'h00044801);
      for (int i = 0; i < 4; i++) begin
         x = {12'h0, PHY_W[15 - i], 15'h0, ROM_W[15 - i], 3'h0};
         wr(8'h48, 32'h00054803);
         repeat (4) @(posedge core_clk);
         chk_rd(8'h48, 32'h00080008, x);
         wr(8'h48, 32'h00044801);
      end
   endtask
   task automatic t_lost();
      pulse(3'h4, 3);
      chk_rd(8'h40, 32'hFFFFFFFF, 32'h3);
      chk_rd(8'h40, 32'hFFFFFFFF, 32'h0);
      pulse(3'h4, 65536);
      chk_rd(8'h40, 32'hFFFFFFFF, 32'h00010000);
      chk_rd(8'h40, 32'hFFFFFFFF, 32'h0);
      chk_rd(8'h70, 32'hF, 32'h4);
   endtask
   task automatic irq_case(input logic [2:0] e, input logic [31:0] p, f);
      wr(8'h38, p);
      pulse(e, 1);
      repeat (3) @(posedge core_clk);
      `CHK(irq, 1'b0)
      wr(8'h38, f);
      repeat (2) @(posedge core_clk);
      `CHK(irq, 1'b1)
      chk_rd(8'h70, 32'hF, {29'h0, e});
      repeat (2) @(posedge core_clk);
      `CHK(irq, 1'b0)
   endtask
   task automatic t_irq();
      wr(8'h74, 32'hF);
      irq_case(3'h1, 32'h00008001, 32'h00010001);
      irq_case(3'h2, 32'h00010002, 32'h00008002);
      wr(8'h38, 32'h00018003);
      wr(8'h74, 32'h0);
      pulse(3'h1, 1);
      repeat (3) @(posedge core_clk);
      `CHK(irq, 1'b0)
      chk_rd(8'h70, 32'hF, 32'h1);
   endtask
   task automatic t_timer();
      wr(8'h58, 32'h3);
      chk_rd(8'h58, 32'h1FFFF, 32'h3);
      repeat (20) @(posedge core_clk);
      chk_rd(8'h58, 32'h1FFFF, 32'h0);
      chk_rd(8'h70, 32'h8, 32'h8);
      wr(8'h58, 32'h00010002);
      repeat (30) @(posedge core_clk);
      chk_rd(8'h70, 32'h8, 32'h8);
      repeat (30) @(posedge core_clk);
      chk_rd(8'h70, 32'h8, 32'h8);
      chk_rd(8'h58, 32'h10000, 32'h10000);
      wr(8'h58, 32'h0);
      wr(8'h68, 32'hFFFFFFFF);
      chk_rd(8'h68, 32'hFFFFFFFF, `CSRT_WAKE_WMASK);
      chk_rd(8'h80, 32'hFFFFFFFF, 32'h0);
   endtask

   // ------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Free-running core clock.
   initial begin
      forever #20 core_clk = ~core_clk;
   end

   // Reset, then every scenario in turn.
   initial begin
      {resetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      {tx_done_evt, tx_stopped_evt, pkt_lost_evt} = 3'h0;
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      t_serial();
      t_bitbang();
      t_lost();
      t_irq();
      t_timer();
      results();
   end

   // The scenarios need about 66000 cycles; cut a hang off well after.
   initial begin
      repeat (90000) @(posedge core_clk);
      bad_count++;
      results();
   end
endmodule

bind csrt_top csrt_monitor csrt_monitor_inst (.core_clk, .resetn, .hsel,
   .haddr, .htrans, .hwrite, .hwdata, .hready, .mgmt_clk,
   .mgmt_write_bit, .mgmt_write_oe, .eeprom_data_to_rom, .eeprom_sclk,
   .eeprom_chip_select, .eeprom_read_ctl, .eeprom_write_ctl,
   .eeprom_select_ctl);
